// [rtl/conv_cfg_pkg.sv]
// Shared constants and carriers for the per-channel converter configuration bank.
// Assumes a command decoder upstream that delivers single register writes and reads.
package conv_cfg_pkg;

	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_PG_THRESH = 8'hd9;
	localparam logic [7:0] CMD_STEP_RATE = 8'hda;
	localparam logic [7:0] CMD_SHED = 8'he5;
	localparam logic [7:0] CMD_FUNC_CTRL = 8'hea;

	// ==========================================================
	// Field positions
	localparam int PG_FALL_LSB = 2;
	localparam int PG_RISE_LSB = 0;
	localparam int SHED_REG_BIT = 0;
	localparam int SHED_PIN_BIT = 1;
	localparam int SINK_N_BIT = 9;
	localparam int PHASE_MULTI_BIT = 3;

	// Writable masks; other bits keep their manufacturer value
	localparam logic [7:0] PG_THRESH_MASK = 8'h0f;
	localparam logic [7:0] STEP_RATE_MASK = 8'h0f;
	localparam logic [7:0] SHED_MASK = 8'h03;
	localparam logic [15:0] FUNC_CTRL_MASK = 16'h0208;

	// Reset values
	localparam logic [7:0] PG_THRESH_RST = 8'h00;
	localparam logic [7:0] STEP_RATE_RST = 8'h04;
	localparam logic [7:0] SHED_RST = 8'h00;
	localparam logic [15:0] FUNC_CTRL_RST = 16'h0000;

	// ==========================================================
	// Thresholds in tenths of a percent of reference
	localparam logic [9:0] PG_FALL_69 = 10'd690;
	localparam logic [9:0] PG_FALL_STEP = 10'd50;
	localparam logic [9:0] PG_RISE_90 = 10'd900;
	localparam logic [9:0] PG_RISE_STEP = 10'd25;

	// ==========================================================
	// Step timing: base 20 us, 2.5 us per LSB, per 2 mV step
	localparam int CLK_MHZ = 50;
	localparam int STEP_BASE_NS = 20000;
	localparam int STEP_LSB_NS = 2500;
	localparam int STEP_BASE_CYC = STEP_BASE_NS * CLK_MHZ / 1000;
	localparam int STEP_LSB_CYC = STEP_LSB_NS * CLK_MHZ / 1000;
	localparam int STEP_CNT_W = 12;
	localparam logic [11:0] STEP_MV = 12'd2;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] cmd;
		logic [15:0] wdata;
	} reg_req_type;

	typedef struct packed {
		logic ack;
		logic err;
		logic [15:0] rdata;
	} reg_rsp_type;

	typedef struct packed {
		logic overcurrent;
		logic overvoltage;
		logic overtemp;
	} fault_in_type;

endpackage

// [rtl/sync2.sv]
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is a slow level such as a board pin.
module sync2 (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Level
	input wire logic din,
	output logic dout
);
	logic meta_reg;
	logic meta_next;
	logic out_next;

	always_comb begin
		meta_next = din;
		out_next = meta_reg;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_reg <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			dout <= out_next;
		end
	end
endmodule // sync2

// [rtl/step_timer.sv]
// Divider issuing one-cycle pulses at a programmable period.
// Assumes the period input is stable for the length of a period.
module step_timer #(
	parameter int W = 12
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic [W-1:0] period,
	output logic tick
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic tick_next;

	always_comb begin
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (!run) begin
			cnt_next = '0;
		end else if (cnt_reg + W'(1) >= period) begin
			cnt_next = '0;
			tick_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + W'(1);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			tick <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick <= tick_next;
		end
	end
endmodule // step_timer

// [rtl/conv_cfg_regs.sv]
// Per-channel configuration bank: power-good thresholds, undervoltage protection,
// post-soft-start step slewing, phase shedding and the function control word.
// Assumes register requests arrive already decoded from the management bus, on mclk,
// and that feedback and reference levels come from a converter on the same clock.
// The phase-shed pin is asynchronous and is synchronised inside.
// Reserved bits are constants here; a host cannot move them by writing.
// Functional notes
// - Fall threshold codes give 69/74/79/84 percent; rise codes 90/92.5/95/97.5.
// - Undervoltage threshold equals fall threshold; trip when feedback falls below it.
// - Undervoltage takes the same reaction as overcurrent.
// - Power-good output is low whenever any fault is present.
// - After soft start, step in 2 mV units; 20 us plus 2.5 us per LSB.
// - Step rate is ignored during soft start; soft start ramps on its own.
// - Register shed bit set disables slave phases in multi-phase operation.
// - With pin control set, low phase-shed pin enters low power; ignored otherwise.
// - Master phase is never disabled by the shed settings.
// - Control bit 9 clear enables output sink mode; set disables it.
// - Control bit 3 clear selects single-phase; set selects multi-phase.
// - Phase operation bit modifies the ramp amplitude chosen by the ramp field.
// - Overcurrent reaction select: clear latches off, set retries.
module conv_cfg_regs
	import conv_cfg_pkg::*;
#(
	parameter int PHASES = 4,
	parameter int VW = 12
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register access
	input conv_cfg_pkg::reg_req_type req,
	output conv_cfg_pkg::reg_rsp_type rsp,
	// Converter status
	input wire logic [VW-1:0] feedback_voltage,
	input wire logic [VW-1:0] reference_voltage,
	input wire logic soft_start_active,
	input wire logic [VW-1:0] target_voltage,
	input wire conv_cfg_pkg::fault_in_type faults,
	input wire logic overcurrent_reaction_select,
	input wire logic [2:0] ramp_field,
	// Pin
	input wire logic phase_shed_pin,
	// Converter controls
	output logic power_good_output,
	output logic undervoltage_protection,
	output logic fault_latch_off,
	output logic fault_retry,
	output logic [VW-1:0] slewed_voltage,
	output logic [PHASES-1:0] phase_enable,
	output logic output_sink_mode,
	output logic multi_phase,
	output logic [3:0] ramp_select
);
	import conv_cfg_pkg::*;

	// ==========================================================
	// Register file
	logic [7:0] pg_thresh_reg;
	logic [7:0] pg_thresh_next;
	logic [7:0] step_rate_reg;
	logic [7:0] step_rate_next;
	logic [7:0] shed_reg;
	logic [7:0] shed_next;
	logic [15:0] func_ctrl_reg;
	logic [15:0] func_ctrl_next;
	reg_rsp_type rsp_next;

	always_comb begin
		pg_thresh_next = pg_thresh_reg;
		step_rate_next = step_rate_reg;
		shed_next = shed_reg;
		func_ctrl_next = func_ctrl_reg;
		rsp_next = '0;

		if (req.wr) begin
			rsp_next.ack = 1'b1;
			// Masked merge keeps the fixed bits
			case (req.cmd)
				CMD_PG_THRESH: begin
					pg_thresh_next = (pg_thresh_reg & ~PG_THRESH_MASK)
						| (req.wdata[7:0] & PG_THRESH_MASK);
				end
				CMD_STEP_RATE: begin
					step_rate_next = (step_rate_reg & ~STEP_RATE_MASK)
						| (req.wdata[7:0] & STEP_RATE_MASK);
				end
				CMD_SHED: begin
					shed_next = (shed_reg & ~SHED_MASK)
						| (req.wdata[7:0] & SHED_MASK);
				end
				CMD_FUNC_CTRL: begin
					// A host that ignores the fixed bits still cannot alter them
					func_ctrl_next = (func_ctrl_reg & ~FUNC_CTRL_MASK)
						| (req.wdata & FUNC_CTRL_MASK);
				end
				default: rsp_next.err = 1'b1;
			endcase
		end else if (req.rd) begin
			rsp_next.ack = 1'b1;
			// Narrow registers read back zero-extended
			case (req.cmd)
				CMD_PG_THRESH: rsp_next.rdata = {8'h00, pg_thresh_reg};
				CMD_STEP_RATE: rsp_next.rdata = {8'h00, step_rate_reg};
				CMD_SHED: rsp_next.rdata = {8'h00, shed_reg};
				CMD_FUNC_CTRL: rsp_next.rdata = func_ctrl_reg;
				default: rsp_next.err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pg_thresh_reg <= PG_THRESH_RST;
			step_rate_reg <= STEP_RATE_RST;
			shed_reg <= SHED_RST;
			func_ctrl_reg <= FUNC_CTRL_RST;
			rsp <= '0;
		end else begin
			pg_thresh_reg <= pg_thresh_next;
			step_rate_reg <= step_rate_next;
			shed_reg <= shed_next;
			func_ctrl_reg <= func_ctrl_next;
			rsp <= rsp_next;
		end
	end

	// ==========================================================
	// Threshold decode, in tenths of a percent
	// Levels compare as products, so no divider is needed; widths cover full scale
	// Fall codes step by five percent, rise codes by two and a half
	logic [1:0] power_good_fall_threshold;
	logic [1:0] power_good_rise_threshold;
	logic [9:0] fall_permille;
	logic [9:0] rise_permille;
	logic [VW+9:0] fb_scaled;
	logic [VW+9:0] fall_level;
	logic [VW+9:0] rise_level;

	always_comb begin
		power_good_fall_threshold = pg_thresh_reg[PG_FALL_LSB +: 2];
		power_good_rise_threshold = pg_thresh_reg[PG_RISE_LSB +: 2];
		fall_permille = PG_FALL_69 + 10'(PG_FALL_STEP * power_good_fall_threshold);
		rise_permille = PG_RISE_90 + 10'(PG_RISE_STEP * power_good_rise_threshold);
		fb_scaled = (VW+10)'(feedback_voltage) * (VW+10)'(1000);
		fall_level = (VW+10)'(reference_voltage) * (VW+10)'(fall_permille);
		rise_level = (VW+10)'(reference_voltage) * (VW+10)'(rise_permille);
	end

	// ==========================================================
	// Protection and power good
	logic uv_next;
	logic pg_next;
	logic any_fault;

	always_comb begin
		uv_next = !soft_start_active && (fb_scaled < fall_level);
		any_fault = uv_next | faults.overcurrent | faults.overvoltage | faults.overtemp;

		// Hysteresis: rise at or above the on level, drop below the off level
		pg_next = power_good_output;
		if (any_fault || soft_start_active) begin
			pg_next = 1'b0;
		end else if (fb_scaled >= rise_level) begin
			pg_next = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			undervoltage_protection <= 1'b0;
			power_good_output <= 1'b0;
		end else begin
			undervoltage_protection <= uv_next;
			power_good_output <= pg_next;
		end
	end

	// ==========================================================
	// Fault reaction
	logic reaction_trip;
	logic latch_next;
	logic retry_next;

	always_comb begin
		// Undervoltage shares the overcurrent reaction, so one select serves both
		reaction_trip = uv_next | faults.overcurrent;
		latch_next = reaction_trip & !overcurrent_reaction_select;
		retry_next = reaction_trip & overcurrent_reaction_select;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fault_latch_off <= 1'b0;
			fault_retry <= 1'b0;
		end else begin
			fault_latch_off <= latch_next;
			fault_retry <= retry_next;
		end
	end

	// ==========================================================
	// Post soft-start slewing
	logic [STEP_CNT_W-1:0] step_period;
	logic step_tick;
	logic slew_run;
	logic [VW:0] slew_wide;
	logic [VW:0] target_wide;
	logic [VW-1:0] slew_next;

	always_comb begin
		step_period = STEP_CNT_W'(STEP_BASE_CYC)
			+ STEP_CNT_W'(STEP_LSB_CYC * step_rate_reg[3:0]);
		// Timer idles in soft start, so the first step after it takes a full period
		slew_run = !soft_start_active && (slewed_voltage != target_voltage);
	end

	step_timer #(
		.W(STEP_CNT_W)
	) u_step_timer (
		.mclk(mclk),
		.rst(rst),
		.run(slew_run),
		.period(step_period),
		.tick(step_tick)
	);

	always_comb begin
		slew_next = slewed_voltage;
		// One spare bit keeps the step tests from wrapping at the ends of the range
		slew_wide = {1'b0, slewed_voltage};
		target_wide = {1'b0, target_voltage};
		if (soft_start_active) begin
			// Soft start has its own ramp, so track the target directly
			slew_next = target_voltage;
		end else if (step_tick) begin
			if (target_wide > slew_wide + (VW+1)'(STEP_MV)) begin
				slew_next = slewed_voltage + VW'(STEP_MV);
			end else if (target_wide + (VW+1)'(STEP_MV) < slew_wide) begin
				slew_next = slewed_voltage - VW'(STEP_MV);
			end else begin
				slew_next = target_voltage;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			slewed_voltage <= '0;
		end else begin
			slewed_voltage <= slew_next;
		end
	end

	// ==========================================================
	// Phase shedding and control word
	logic shed_pin_sync;
	logic low_power;
	logic [PHASES-1:0] phase_next;
	logic sink_next;
	logic multi_next;
	logic [3:0] ramp_next;

	// Pin effect lands three edges after it moves: two sync stages and the output flop
	sync2 u_shed_sync (
		.mclk(mclk),
		.rst(rst),
		.din(phase_shed_pin),
		.dout(shed_pin_sync)
	);

	always_comb begin
		low_power = shed_reg[SHED_REG_BIT]
			| (shed_reg[SHED_PIN_BIT] & !shed_pin_sync);
		// A single phase has no slaves, so shedding waits for multi-phase operation
		phase_next = '1;
		if (low_power && func_ctrl_reg[PHASE_MULTI_BIT]) begin
			phase_next = PHASES'(1);
		end

		sink_next = !func_ctrl_reg[SINK_N_BIT];
		multi_next = func_ctrl_reg[PHASE_MULTI_BIT];
		// Multi-phase doubles the ramp step index and adds one
		if (func_ctrl_reg[PHASE_MULTI_BIT]) begin
			ramp_next = {ramp_field, 1'b1};
		end else begin
			ramp_next = {1'b0, ramp_field};
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phase_enable <= '1;
			output_sink_mode <= 1'b0;
			multi_phase <= 1'b0;
			ramp_select <= '0;
		end else begin
			phase_enable <= phase_next;
			output_sink_mode <= sink_next;
			multi_phase <= multi_next;
			ramp_select <= ramp_next;
		end
	end
endmodule // conv_cfg_regs

// [tb/conv_cfg_regs_assertions.sv]
// Checker for the configuration bank, bound to conv_cfg_regs.
// Assumes only the bank's ports are visible.
module conv_cfg_regs_checker
	import conv_cfg_pkg::*;
#(
	parameter int PHASES = 4,
	parameter int VW = 12
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Watched ports
	input conv_cfg_pkg::reg_req_type req,
	input conv_cfg_pkg::reg_rsp_type rsp,
	input wire logic soft_start_active,
	input wire conv_cfg_pkg::fault_in_type faults,
	input wire logic overcurrent_reaction_select,
	input wire logic power_good_output,
	input wire logic undervoltage_protection,
	input wire logic fault_latch_off,
	input wire logic fault_retry,
	input wire logic [VW-1:0] slewed_voltage,
	input wire logic [PHASES-1:0] phase_enable,
	input wire logic output_sink_mode,
	input wire logic multi_phase
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic ctrl_wr;
	logic mapped;
	assign ctrl_wr = req.wr && req.cmd == CMD_FUNC_CTRL;
	assign mapped = req.cmd inside {CMD_PG_THRESH, CMD_STEP_RATE, CMD_SHED, CMD_FUNC_CTRL};

	// ====
	// Register bus
	AST_ACK: assert property (rsp.ack == $past(req.wr || req.rd))
		else $error("ack not one cycle after request");
	AST_ERR: assert property ((req.wr || req.rd) && !mapped |=> rsp.err)
		else $error("unmapped command not refused");
	AST_SINK: assert property (ctrl_wr |=> ##1 output_sink_mode == !$past(req.wdata[9], 2))
		else $error("sink mode does not follow control bit");
	AST_MULTI: assert property (ctrl_wr |=> ##1 multi_phase == $past(req.wdata[3], 2))
		else $error("phase mode does not follow control bit");

	// ====
	// Converter controls
	AST_MASTER: assert property (phase_enable[0])
		else $error("master phase disabled");
	AST_FAULT_PG: assert property (|faults |-> ##[1:2] !power_good_output)
		else $error("power good high during fault");
	AST_UV_PG: assert property ($rose(undervoltage_protection) |-> ##[0:1] !power_good_output)
		else $error("power good high during undervoltage");
	AST_UV_LATCH: assert property (undervoltage_protection && !overcurrent_reaction_select
		|-> ##[0:2] fault_latch_off)
		else $error("undervoltage did not latch off");
	AST_UV_RETRY: assert property (undervoltage_protection && overcurrent_reaction_select
		|-> ##[0:2] fault_retry)
		else $error("undervoltage did not retry");
	AST_SLEW: assert property (!soft_start_active && !$past(soft_start_active)
		&& $changed(slewed_voltage) |-> slewed_voltage == $past(slewed_voltage) + VW'(2)
		|| $past(slewed_voltage) == slewed_voltage + VW'(2))
		else $error("slew step is not two units");

	COV_READ: cover property (rsp.ack && !rsp.err && rsp.rdata != 16'h0000);
	COV_SHED: cover property (multi_phase && phase_enable == PHASES'(1));
	COV_UV: cover property ($rose(undervoltage_protection));
endmodule // conv_cfg_regs_checker

bind conv_cfg_regs conv_cfg_regs_checker #(.PHASES(PHASES), .VW(VW)) u_conv_cfg_regs_checker (
	.mclk, .rst, .req, .rsp, .soft_start_active, .faults, .overcurrent_reaction_select,
	.power_good_output, .undervoltage_protection, .fault_latch_off, .fault_retry,
	.slewed_voltage, .phase_enable, .output_sink_mode, .multi_phase);

// [tb/host_model.sv]
// Management host model: single register writes and reads on one-cycle strobes.
// Assumes the bank answers within a few cycles of a taken strobe.
module host_model
	import conv_cfg_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Request and answer
	output conv_cfg_pkg::reg_req_type req,
	input conv_cfg_pkg::reg_rsp_type rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rdata;
	logic err;
	initial req = '0;

	// ====
	// Strobe held for exactly one taken edge, then answer awaited
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
		int n;
		@(posedge mclk);
		req <= '{wr: w, rd: !w, cmd: c, wdata: d};
		@(posedge mclk);
		req <= '0;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (rsp.ack !== 1'b1 && n < 4);
		rdata = rsp.rdata;
		err = rsp.err;
	endtask

	task automatic write(input logic [7:0] c, input logic [15:0] d);
		if (c == CMD_FUNC_CTRL)
			d = (d & FUNC_CTRL_MASK) | (FUNC_CTRL_RST & ~FUNC_CTRL_MASK);
		xfer(1, c, d);
	endtask
endmodule // host_model

// [tb/test_conv_cfg_regs.sv]
// Bench for conv_cfg_regs: threshold table rows, then hand-written cases.
// Assumes host_model issues all register traffic.
module test_conv_cfg_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import conv_cfg_pkg::*;
	logic mclk = 0, rst = 1, ss = 0, pin = 1, ocsel = 0, pg, uv, lat, rty, sink, multi;
	logic [11:0] fb = 12'd1000, ref_v = 12'd1000, target = 12'h000, slew, v;
	fault_in_type faults = '0;
	logic [2:0] ramp_f = 3'h5;
	logic [3:0] pen, ramp;
	reg_req_type req;
	reg_rsp_type rsp;
	int mismatches = 0, samples_checked = 0, n;
	typedef struct packed {
		logic [7:0] code;
		logic sel;
		logic [11:0] fall;
		logic [11:0] rise;
	} row_type;
	row_type rows [4] = '{'{8'h03, 1'b0, 12'd690, 12'd975}, '{8'h06, 1'b1, 12'd740, 12'd950},
		'{8'h09, 1'b0, 12'd790, 12'd925}, '{8'h0c, 1'b1, 12'd840, 12'd900}};
	logic [7:0] cmds [4] = '{CMD_PG_THRESH, CMD_STEP_RATE, CMD_SHED, CMD_FUNC_CTRL};
	logic [15:0] rstv [4] = '{PG_THRESH_RST, STEP_RATE_RST, SHED_RST, FUNC_CTRL_RST};
	logic [15:0] mskv [4] = '{PG_THRESH_MASK, STEP_RATE_MASK, SHED_MASK, FUNC_CTRL_MASK};
	always #10 mclk = ~mclk;

	conv_cfg_regs u_conv_cfg_regs (.mclk, .rst, .req, .rsp, .feedback_voltage(fb),
		.reference_voltage(ref_v), .soft_start_active(ss), .target_voltage(target), .faults,
		.overcurrent_reaction_select(ocsel), .ramp_field(ramp_f), .phase_shed_pin(pin),
		.power_good_output(pg), .undervoltage_protection(uv), .fault_latch_off(lat),
		.fault_retry(rty), .slewed_voltage(slew), .phase_enable(pen), .output_sink_mode(sink),
		.multi_phase(multi), .ramp_select(ramp));
	host_model u_host_model (.mclk, .req, .rsp);

	// ====
	// Helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask
	task automatic put(input logic [11:0] x);
		fb <= x;
		cyc(4);
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		u_host_model.write(c, d);
		cyc(2);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] exp);
		u_host_model.xfer(0, c, 16'h0000);
		chk(u_host_model.rdata, exp);
	endtask
	task automatic do_reset();
		rst <= 1;
		cyc(12);
		rst <= 0;
		cyc(2);
	endtask
	// Cycles until the slewed level moves; capped so a stuck output cannot hang
	task automatic gap(output int k);
		logic [11:0] s;
		s = slew;
		k = 0;
		while (slew === s && k < 5000) begin
			@(posedge mclk);
			k++;
		end
	endtask
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ====
	// Sequence
	initial begin
		foreach (rows[i]) begin
			fb <= rows[i].fall;
			ocsel <= rows[i].sel;
			do_reset();
			wr(CMD_PG_THRESH, {8'h00, rows[i].code});
			put(rows[i].rise - 12'd1);
			chk(pg, 0);
			put(rows[i].rise);
			chk(pg, 1);
			put(rows[i].fall);
			chk({pg, uv}, 2'b10);
			put(rows[i].fall - 12'd1);
			chk({pg, uv, lat, rty}, {2'b01, !rows[i].sel, rows[i].sel});
			$display("row %0d done", i);
		end
		fb <= 12'd1000;
		do_reset();
		u_host_model.xfer(0, 8'h00, 16'h0000);
		chk(u_host_model.err, 1);
		for (int k = 0; k < 4; k++) begin
			rd(cmds[k], rstv[k]);
			u_host_model.xfer(1, cmds[k], 16'hffff);
			rd(cmds[k], mskv[k]);
		end
		$display("register test done");
		do_reset();
		wr(CMD_SHED, 16'h0001);
		chk({sink, multi, ramp, pen}, {2'b10, 4'h5, 4'hf});
		wr(CMD_FUNC_CTRL, 16'h0208);
		chk({sink, multi, ramp, pen}, {2'b01, 4'hb, 4'h1});
		wr(CMD_SHED, 16'h0002);
		pin <= 0;
		cyc(4);
		chk(pen, 4'h1);
		pin <= 1;
		cyc(4);
		chk(pen, 4'hf);
		wr(CMD_SHED, 16'h0000);
		pin <= 0;
		cyc(4);
		chk(pen, 4'hf);
		$display("shed test done");
		do_reset();
		chk(pg, 1);
		for (int k = 0; k < 3; k++) begin
			faults <= 3'b001 << k;
			cyc(3);
			chk(pg, 0);
			faults <= '0;
			cyc(3);
		end
		$display("fault test done");
		ss <= 1;
		do_reset();
		for (int k = 0; k < 2; k++) begin
			ss <= 1;
			target <= 12'd600;
			cyc(4);
			chk(slew, 12'd600);
			wr(CMD_STEP_RATE, k ? 16'h000f : 16'h0000);
			ss <= 0;
			target <= 12'd640;
			gap(n);
			v = slew;
			gap(n);
			chk(n, 1000 + 1875 * k);
			chk(slew - v, 2);
		end
		$display("slew test done");
		print_verdict();
	end

	// Whole run needs under 10000 cycles; four times that means a hang
	initial begin
		repeat (40000) @(posedge mclk);
		mismatches++;
		print_verdict();
	end
endmodule // test_conv_cfg_regs
